/* File: src/adcctl_timing.sv */
// converter timing control: sample phase, bit determination, result load and clamping
// assumes analog comparator inputs are synchronous to clk and the control word is written by the core
`default_nettype none
// Overview of operation
// RQ1: the basic clock is the cpu clock divided by 2, 4, 8 or 16 as bits 15 to 14 of the control word select.
// RQ2: the sample phase lasts six basic clock periods.
// RQ3: after sampling ends the held sample alone decides the result.
// RQ4: every conversion takes exactly 30 basic clock periods plus 2 cpu clock periods.
// RQ5: an input below ground gives 000 and one above the reference gives 3FF.
// RQ6: software keeps the basic clock between 0.5 and 4 MHz.
// RQ7: the 10-bit result sits in the low bits and is loaded only at the end of the conversion.
module adcctl_timing
  import adcctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ctrlWrite,
  input wire logic [15:0] ctrlData,
  input wire logic start,
  input wire adcctl_analog_t analog,
  output logic [15:0] converter_control_register,
  output logic [15:0] resultReg,
  output logic [ADCCTL_RES_W-1:0] dacTrial,
  output adcctl_status_t status
);
  typedef enum logic [1:0] {IDLE, SAMPLE, BITS, LOAD} adcctl_phase_t;

  typedef struct packed {
    adcctl_phase_t phase;
    logic [15:0] ctrl;
    logic [4:0] bcCnt;
    logic [1:0] cpuCnt;
    logic [ADCCTL_RES_W-1:0] sar;
    logic [ADCCTL_RES_W-1:0] trial;
    logic [3:0] bitIdx;
    logic clampLow;
    logic clampHigh;
    logic [15:0] result;
    adcctl_status_t stat;
  } adcctl_state_t;

  adcctl_state_t st;
  adcctl_state_t next_st;
  logic bcTick;
  logic running;
  logic [1:0] basic_clock_divider_select;

  assign basic_clock_divider_select = st.ctrl[ADCCTL_DIVSEL_HI:ADCCTL_DIVSEL_LO];
  assign running = (st.phase == SAMPLE) || (st.phase == BITS);

  // basic clock enable
  adcctl_clkdiv u_div (
    .clk(clk),
    .rst_b(rst_b),
    .run(running),
    .divSel(basic_clock_divider_select),
    .bcTick(bcTick)
  );

  // one-hot trial bit for a given bit index
  function automatic logic [ADCCTL_RES_W-1:0] bitMask(input logic [3:0] idx);
    bitMask = ADCCTL_RES_W'(1) << idx;
  endfunction

  // trial code after one decision: keep or drop the bit under test,
  // then raise the next lower bit unless the last one was just decided
  function automatic logic [ADCCTL_RES_W-1:0] nextTrial(
    input logic [ADCCTL_RES_W-1:0] sar,
    input logic [3:0] idx,
    input logic cmp
  );
    logic [ADCCTL_RES_W-1:0] kept;
    kept = cmp ? (sar | bitMask(idx)) : sar;
    if (idx == 4'h0)
      nextTrial = kept;
    else
      nextTrial = kept | bitMask(idx - 4'h1);
  endfunction

  // true on the final basic period of a phase of the given length
  function automatic logic lastTick(input logic [4:0] cnt, input logic [4:0] span);
    lastTick = (cnt == span - 5'h01);
  endfunction

  // result word for the load step: clamps win over the converted code,
  // and a level below ground wins over one above the reference
  function automatic logic [15:0] resultWord(
    input logic low,
    input logic high,
    input logic [ADCCTL_RES_W-1:0] code
  );
    logic [ADCCTL_RES_W-1:0] val;
    if (low)
      val = ADCCTL_RES_ZERO; // RQ5
    else if (high)
      val = ADCCTL_RES_FULL; // RQ5
    else
      val = code;
    resultWord = {6'h00, val}; // RQ7
  endfunction

  // timeline of one conversion with a divide by n, counted from the start edge:
  //   edge 0           start taken, busy and sample hold rise
  //   edges n to 6n    six basic ticks, the last one closes the sample phase
  //   edge 6n          clamp flags frozen, first trial code 200 shown
  //   edges 7n to 30n  twenty four basic ticks, a decision on every second one from 8n to 26n
  //   edge 30n         last basic tick, load phase entered
  //   edge 30n+2       result register loaded, done pulse, busy falls
  // so busy stands exactly 30 basic periods plus 2 cpu periods
  // hazard: the divider select must not change while busy,
  // or the phase lengths above no longer hold
  // note: a start while busy is dropped without any indication

  // phase sequencing
  always_comb
  begin
    next_st = st;
    next_st.stat.done = 1'b0;
    if (ctrlWrite)
      next_st.ctrl = ctrlData;
    unique case (st.phase)
      IDLE:
      begin
        if (start)
        begin
          next_st.phase = SAMPLE;
          next_st.bcCnt = 5'h00;
          next_st.sar = '0;
          next_st.clampLow = 1'b0;
          next_st.clampHigh = 1'b0;
          next_st.stat.busy = 1'b1;
          next_st.stat.sampleHold = 1'b1;
        end
      end
      SAMPLE:
      begin
        // track input range while the sample capacitor follows the pin
        next_st.clampLow = analog.belowGround;
        next_st.clampHigh = analog.aboveRef;
        if (bcTick)
        begin
          if (lastTick(st.bcCnt, ADCCTL_SAMPLE_BC)) // RQ2
          begin
            next_st.phase = BITS;
            next_st.bcCnt = 5'h00;
            next_st.bitIdx = 4'(ADCCTL_RES_W - 1);
            next_st.trial = bitMask(4'(ADCCTL_RES_W - 1));
            next_st.stat.sampleHold = 1'b0; // RQ3
          end
          else
            next_st.bcCnt = st.bcCnt + 5'h01;
        end
      end
      BITS:
      begin
        // ten decisions spread over the 24 remaining basic periods
        if (bcTick)
        begin
          next_st.bcCnt = st.bcCnt + 5'h01;
          if (st.bcCnt[0] && st.bitIdx != 4'hF)
          begin
            if (analog.cmpOut)
              next_st.sar = st.sar | bitMask(st.bitIdx); // RQ3
            next_st.bitIdx = st.bitIdx - 4'h1;
            next_st.trial = nextTrial(st.sar, st.bitIdx, analog.cmpOut); // RQ3
          end
          if (lastTick(st.bcCnt, ADCCTL_BITS_BC)) // RQ4
          begin
            next_st.phase = LOAD;
            next_st.cpuCnt = 2'h0;
          end
        end
      end
      LOAD:
      begin
        // two cpu cycles to load the result register
        if (st.cpuCnt == ADCCTL_LOAD_CPU - 2'h1) // RQ4
        begin
          next_st.phase = IDLE;
          next_st.stat.busy = 1'b0;
          next_st.stat.done = 1'b1;
          next_st.result = resultWord(st.clampLow, st.clampHigh, st.sar); // RQ5 RQ7
        end
        else
          next_st.cpuCnt = st.cpuCnt + 2'h1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.phase <= IDLE;
      st.ctrl <= ADCCTL_CTRL_RESET;
      st.result <= ADCCTL_RESREG_RESET;
    end
    else
      st <= next_st;
  end

  assign converter_control_register = st.ctrl;
  assign resultReg = st.result;
  assign dacTrial = st.trial;
  assign status = st.stat;
endmodule
`default_nettype wire

/* File: common/adcctl_pkg.sv */
// package for the converter timing control: divider codes, phase counts, result layout
// assumes a single cpu clock domain and an external successive-approximation analog core
`default_nettype none
package adcctl_pkg;
  // divider select field position in the control word
  localparam int unsigned ADCCTL_DIVSEL_HI = 15;
  localparam int unsigned ADCCTL_DIVSEL_LO = 14;
  localparam logic [1:0] ADCCTL_DIVSEL_RESET = 2'h0;
  // basic clock periods per phase, cpu clock periods for the load phase
  localparam logic [4:0] ADCCTL_SAMPLE_BC = 5'h06;
  localparam logic [4:0] ADCCTL_TOTAL_BC = 5'h1E;
  localparam logic [4:0] ADCCTL_BITS_BC = 5'h18;  // total minus sample
  localparam logic [1:0] ADCCTL_LOAD_CPU = 2'h2;
  // result layout
  localparam int unsigned ADCCTL_RES_W = 10;
  localparam logic [9:0] ADCCTL_RES_ZERO = 10'h000;
  localparam logic [9:0] ADCCTL_RES_FULL = 10'h3FF;
  localparam logic [15:0] ADCCTL_RESREG_RESET = 16'h0000;
  localparam logic [15:0] ADCCTL_CTRL_RESET = 16'h0000;
  // clamp indication and comparator decision from the analog comparator front end
  typedef struct packed {
    logic belowGround;
    logic aboveRef;
    logic cmpOut;
  } adcctl_analog_t;
  // status toward the core
  typedef struct packed {
    logic sampleHold;
    logic busy;
    logic done;
  } adcctl_status_t;
endpackage
`default_nettype wire

/* File: src/adcctl_clkdiv.sv */
// basic clock enable generator: one-cycle pulse every 2, 4, 8 or 16 cpu cycles
// assumes divider select is stable during a conversion
`default_nettype none
module adcctl_clkdiv
  import adcctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [1:0] divSel,
  output logic bcTick
);
  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } adcctl_div_t;

  adcctl_div_t st;
  adcctl_div_t next_st;
  logic [3:0] limit;

  // terminal count per selection: 2^(sel+1)-1
  always_comb
  begin
    limit = 4'((5'h02 << divSel) - 5'h01); // RQ1
    next_st = st;
    next_st.tick = 1'b0;
    // preload one so the first tick is sampled n cycles after the start edge
    if (!run)
    begin
      next_st.cnt = 4'h1; // RQ4
    end
    else if (st.cnt >= limit)
    begin
      next_st.cnt = 4'h0;
      next_st.tick = 1'b1; // RQ1
    end
    else
    begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  assign bcTick = st.tick;
endmodule
`default_nettype wire

/* File: bench/adcctl_timing_monitor.sv */
// port checker for the converter timing control
// assumes one clock domain, bound onto adcctl_timing
`default_nettype none
module adcctl_timing_monitor
  import adcctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ctrlWrite,
  input wire logic [15:0] ctrlData,
  input wire logic start,
  input wire adcctl_analog_t analog,
  input wire logic [15:0] converter_control_register,
  input wire logic [15:0] resultReg,
  input wire logic [ADCCTL_RES_W-1:0] dacTrial,
  input wire adcctl_status_t status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [9:0] cnt;
  logic [9:0] tot;
  // busy cycles so far and expected length
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt <= 10'h000;
    else
      cnt <= status.busy ? cnt + 10'h001 : 10'h000;
  end
  assign tot = (10'h03C << converter_control_register[15:14]) + 10'h002;
  sequence s_hold;
    status.sampleHold[*8] ##[1:300] !status.sampleHold;
  endsequence
  sequence s_lo;
    $fell(status.sampleHold) && $past(analog.belowGround);
  endsequence
  sequence s_hi;
    $fell(status.sampleHold) && $past(analog.aboveRef && !analog.belowGround);
  endsequence
  property p_ctl; ctrlWrite |=> converter_control_register == $past(ctrlData); endproperty
  property p_beg; start && !status.busy |=> status.busy && status.sampleHold; endproperty
  property p_smp; $rose(status.sampleHold) |-> s_hold; endproperty
  property p_trl; $fell(status.sampleHold) |-> status.busy ##[0:1] dacTrial == 10'h200; endproperty
  property p_dur; status.done |-> cnt == tot; endproperty
  property p_zero; s_lo |-> ##[1:483] (status.done && resultReg == 16'h0000); endproperty
  property p_full; s_hi |-> ##[1:483] (status.done && resultReg == 16'h03FF); endproperty
  property p_res; $changed(resultReg) |-> status.done; endproperty
  a_ctl: assert property (p_ctl) else $error("control word not loaded");
  a_beg: assert property (p_beg) else $error("start not taken");
  a_smp: assert property (p_smp) else $error("sample phase length wrong");
  a_trl: assert property (p_trl) else $error("no trial after sampling");
  a_dur: assert property (p_dur) else $error("conversion length wrong");
  a_zero: assert property (p_zero) else $error("low clamp wrong");
  a_full: assert property (p_full) else $error("high clamp wrong");
  a_res: assert property (p_res) else $error("result changed early");
endmodule
bind adcctl_timing adcctl_timing_monitor i_adcctl_timing_monitor (.clk, .rst_b, .ctrlWrite, .ctrlData,
  .start, .analog, .converter_control_register, .resultReg, .dacTrial, .status);
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the converter timing control
// assumes the timing block alone, inputs driven at falling edges
`default_nettype none
module tb;
  import adcctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, ctrlWrite, start;
  logic [15:0] ctrlData, converter_control_register, resultReg;
  logic [9:0] dacTrial;
  adcctl_analog_t analog;
  adcctl_status_t status;
  logic [16:0] lf = 17'h1_7823;
  int failures, n_checks, n;
  adcctl_timing i_adcctl_timing (.clk, .rst_b, .ctrlWrite, .ctrlData, .start, .analog,
    .converter_control_register, .resultReg, .dacTrial, .status);
  // clock and random source
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  function automatic int dur(input logic [1:0] sel);
    return (60 << sel) + 2;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkt(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one conversion; fl is {below, above}, flipped once sampling ends
  task automatic conv(input logic [1:0] sel, input logic [1:0] fl);
    @(negedge clk);
    ctrlWrite = 1'b1;
    ctrlData = {sel, lf[13:0]};
    @(negedge clk);
    chk(converter_control_register, ctrlData);
    ctrlWrite = 1'b0;
    analog = {fl, 1'b0};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (status.done !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
      lf = nxt(lf);
      analog.cmpOut = lf[0];
      start = (n == 5);
      if (status.sampleHold === 1'b0)
        analog[2:1] = ~fl;
    end
    chkt(n, dur(sel));
    if (fl != 2'b00)
      chk(resultReg, fl[1] ? 16'h0000 : 16'h03FF);
    else
      chk({resultReg[15:10], 10'h000}, 16'h0000);
    $display("conv sel %h flags %h cycles %0d done", sel, fl, n);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // reset, every divider with every flag pair, then random ones
  initial
  begin
    rst_b = 1'b0;
    ctrlWrite = 1'b0;
    ctrlData = 16'h0000;
    start = 1'b0;
    analog = 3'h0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    chk(resultReg, 16'h0000);
    for (int i = 0; i < 16; i++)
      conv(i[1:0], i[3:2]);
    // codes 00 and 01 overrun the basic clock limit at 25 MHz: divider corner cases only
    repeat (6) conv({1'b1, lf[1]}, lf[4:3]);
    summarize();
  end
  // hang guard
  initial
  begin
    #1000000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
